// file: hw/hpc_pkg.sv
package hpc_pkg;
	// Word offsets of the register bank
	localparam logic [7:0] HPC_OFS_EMU_CTRL = 8'h04;
	localparam logic [7:0] HPC_OFS_PORT_CTRL = 8'h30;
	localparam logic [7:0] HPC_OFS_WR_ADDR = 8'h34;
	localparam logic [7:0] HPC_OFS_RD_ADDR = 8'h38;
	// Emulation suspend control fields
	localparam int HPC_EMU_FREE_BIT = 0;
	localparam int HPC_EMU_SOFT_BIT = 1;
	// Port control fields
	localparam int HPC_HALFWORD_ORDER_BIT = 0;
	localparam int HPC_H2C_BIT = 1;
	localparam int HPC_C2H_BIT = 2;
	localparam int HPC_RSV3_BIT = 3;
	localparam int HPC_FETCH_BIT = 4;
	localparam int HPC_SRST_BIT = 7;
	localparam int HPC_MIRROR_BIT = 8;
	localparam int HPC_SPLIT_BIT = 9;
	localparam int HPC_SEL_BIT = 11;
	localparam int HPC_RSV10_BIT = 10;
	// Values after reset
	localparam logic [1:0] HPC_EMU_RST = 2'h0;
	localparam logic [31:0] HPC_ADDR_RST = 32'h0000_0000;
	localparam logic HPC_RSV3_VAL = 1'b1;
	// Edges after reset release until the synchronised boot strap is valid
	localparam logic [1:0] HPC_STRAP_EDGES = 2'h3;
	// Which address register a host address access reaches
	typedef enum logic [1:0] {
		HPC_ATGT_WRITE = 2'b01,
		HPC_ATGT_READ = 2'b10
	} hpc_atgt_t;
	// Suspend state machine
	typedef enum logic [2:0] {
		HPC_RUN = 3'b001,
		HPC_DRAIN = 3'b010,
		HPC_HALT = 3'b100
	} hpc_state_t;
endpackage

// file: hw/hpc_sync2.sv
`timescale 1ns/1ps
`default_nettype none
// Two flip-flop level synchroniser
module hpc_sync2 (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic async_in,
	output logic sync_out
);
	logic meta_q;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta_q <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule // hpc_sync2
`default_nettype wire

// file: hw/hpc_regs.sv
// Function
// - Free clear, soft-stop 0: port keeps running during emulation suspend.
// - Free clear, soft-stop 1: halt on suspend after current transaction completes.
// - Free-run set: suspend ignored; otherwise soft-stop chooses behaviour.
// - Host owns control register with full access to writable fields.
// - CPU may only set CPU-to-host irq and clear host-to-CPU irq; other writes ignored except reset.
// - CPU writing 1 to soft reset bit triggers port soft reset.
// - Split mode: select bit 11 picks write (0) or read (1) address.
// - Split mode bit 9 clear: both address registers act as one.
// - Split mode set: host sees two registers; CPU always sees both.
// - Bit 8 is read-only mirror of halfword order, updated on write.
// - Host clears CPU-to-host irq by writing 1; zero writes ignored.
// - Soft reset bit resets to 0 when booting through host port.
// - Other boot: soft reset bit resets to 1; CPU clears before host access.
// - Host irq pin is inverse of CPU-to-host irq bit.
// - Host write 1 raises CPU irq bit, pulsing only if it was clear; CPU write 1 clears it.
// - Halfword order 0: most significant half first; 1: least first.
`timescale 1ns/1ps
`default_nettype none
module hpc_regs
	import hpc_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic host_boot_in,
	// Host side register port
	input wire logic host_wr_in,
	input wire logic host_rd_in,
	input wire logic [7:0] host_addr_in,
	input wire logic [31:0] host_wdata_in,
	output logic [31:0] host_rdata_out,
	// Host address register access (single word strobes)
	input wire logic host_aw_in,
	input wire logic [31:0] host_awdata_in,
	output logic [31:0] host_ardata_out,
	// Local CPU register port
	input wire logic cpu_wr_in,
	input wire logic cpu_rd_in,
	input wire logic [7:0] cpu_addr_in,
	input wire logic [31:0] cpu_wdata_in,
	output logic [31:0] cpu_rdata_out,
	// Port status and controls
	input wire logic emu_suspend_in,
	input wire logic xfer_busy_in,
	output logic port_halt_out,
	output logic soft_reset_out,
	output logic host_irq_n_out,
	output logic cpu_irq_out,
	output logic lsh_first_out,
	output logic fetch_req_out,
	output logic [31:0] wr_addr_out,
	output logic [31:0] rd_addr_out
);
	logic boot_sync;
	logic free_q, soft_q;
	logic halfword_order_q, c2h_q, h2c_q, split_q, sel_q, srst_q, rsv10_q;
	logic [1:0] srst_cnt_q;
	logic [31:0] waddr_q, raddr_q;
	hpc_state_t state_q;
	logic host_ctl_wr, cpu_ctl_wr, host_emu_wr, cpu_emu_wr;
	logic [31:0] ctl_word;
	hpc_atgt_t atgt;

	hpc_sync2 u_boot_sync (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.async_in(host_boot_in),
		.sync_out(boot_sync)
	);

	function automatic logic hit(input logic wr, input logic [7:0] a, input logic [7:0] ofs);
		hit = wr && (a == ofs);
	endfunction

	assign host_ctl_wr = hit(host_wr_in, host_addr_in, HPC_OFS_PORT_CTRL);
	assign cpu_ctl_wr = hit(cpu_wr_in, cpu_addr_in, HPC_OFS_PORT_CTRL);
	assign host_emu_wr = hit(host_wr_in, host_addr_in, HPC_OFS_EMU_CTRL);
	assign cpu_emu_wr = hit(cpu_wr_in, cpu_addr_in, HPC_OFS_EMU_CTRL);

	// Host address target: one shared register unless split mode
	always_comb begin
		if (split_q && sel_q) begin
			atgt = HPC_ATGT_READ;
		end else begin
			atgt = HPC_ATGT_WRITE;
		end
	end

	always_comb begin
		ctl_word = 32'h0000_0000;
		ctl_word[HPC_SEL_BIT] = sel_q;
		ctl_word[HPC_RSV10_BIT] = rsv10_q;
		ctl_word[HPC_SPLIT_BIT] = split_q;
		ctl_word[HPC_MIRROR_BIT] = halfword_order_q;
		ctl_word[HPC_SRST_BIT] = srst_q;
		ctl_word[HPC_RSV3_BIT] = HPC_RSV3_VAL;
		ctl_word[HPC_C2H_BIT] = c2h_q;
		ctl_word[HPC_H2C_BIT] = h2c_q;
		ctl_word[HPC_HALFWORD_ORDER_BIT] = halfword_order_q;
	end

	// Emulation suspend control, written by either side
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			{soft_q, free_q} <= HPC_EMU_RST;
		end else if (host_emu_wr) begin
			free_q <= host_wdata_in[HPC_EMU_FREE_BIT];
			soft_q <= host_wdata_in[HPC_EMU_SOFT_BIT];
		end else if (cpu_emu_wr) begin
			free_q <= cpu_wdata_in[HPC_EMU_FREE_BIT];
			soft_q <= cpu_wdata_in[HPC_EMU_SOFT_BIT];
		end
	end

	// Host-owned configuration fields
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			halfword_order_q <= 1'b0;
			split_q <= 1'b0;
			sel_q <= 1'b0;
			rsv10_q <= 1'b0;
		end else if (host_ctl_wr) begin
			halfword_order_q <= host_wdata_in[HPC_HALFWORD_ORDER_BIT];
			split_q <= host_wdata_in[HPC_SPLIT_BIT];
			sel_q <= host_wdata_in[HPC_SEL_BIT];
			rsv10_q <= host_wdata_in[HPC_RSV10_BIT];
		end
	end

	// CPU-to-host interrupt: CPU sets, host clears, set wins
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			c2h_q <= 1'b0;
		end else if (cpu_ctl_wr && cpu_wdata_in[HPC_C2H_BIT]) begin
			c2h_q <= 1'b1;
		end else if (host_ctl_wr && host_wdata_in[HPC_C2H_BIT]) begin
			c2h_q <= 1'b0;
		end
	end

	// Host-to-CPU interrupt: host sets, CPU clears, set wins
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			h2c_q <= 1'b0;
			cpu_irq_out <= 1'b0;
		end else begin
			cpu_irq_out <= host_ctl_wr && host_wdata_in[HPC_H2C_BIT] && !h2c_q;
			if (host_ctl_wr && host_wdata_in[HPC_H2C_BIT]) begin
				h2c_q <= 1'b1;
			end else if (cpu_ctl_wr && cpu_wdata_in[HPC_H2C_BIT]) begin
				h2c_q <= 1'b0;
			end
		end
	end

	// Soft reset bit: strap followed until the synchroniser has passed it through
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			srst_q <= 1'b0;
			srst_cnt_q <= 2'h0;
			soft_reset_out <= 1'b0;
		end else begin
			soft_reset_out <= cpu_ctl_wr && cpu_wdata_in[HPC_SRST_BIT];
			if (srst_cnt_q != HPC_STRAP_EDGES) begin
				srst_cnt_q <= srst_cnt_q + 2'h1;
				srst_q <= !boot_sync;
			end else if (host_ctl_wr) begin
				srst_q <= host_wdata_in[HPC_SRST_BIT];
			end else if (cpu_ctl_wr) begin
				srst_q <= cpu_wdata_in[HPC_SRST_BIT];
			end
		end
	end

	// Address registers: CPU reaches each separately, host through target
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			waddr_q <= HPC_ADDR_RST;
			raddr_q <= HPC_ADDR_RST;
		end else begin
			if (cpu_wr_in && cpu_addr_in == HPC_OFS_WR_ADDR) begin
				waddr_q <= cpu_wdata_in;
			end else if (host_aw_in && (atgt == HPC_ATGT_WRITE || !split_q)) begin
				waddr_q <= host_awdata_in;
			end
			if (cpu_wr_in && cpu_addr_in == HPC_OFS_RD_ADDR) begin
				raddr_q <= cpu_wdata_in;
			end else if (host_aw_in && (atgt == HPC_ATGT_READ || !split_q)) begin
				raddr_q <= host_awdata_in;
			end
		end
	end

	// Suspend handling, request is same-clock from debug logic
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_q <= HPC_RUN;
		end else begin
			unique case (state_q)
				HPC_RUN: begin
					if (emu_suspend_in && !free_q && soft_q) begin
						state_q <= xfer_busy_in ? HPC_DRAIN : HPC_HALT;
					end
				end
				HPC_DRAIN: begin
					if (!emu_suspend_in || free_q || !soft_q) begin
						state_q <= HPC_RUN;
					end else if (!xfer_busy_in) begin
						state_q <= HPC_HALT;
					end
				end
				HPC_HALT: begin
					if (!emu_suspend_in || free_q || !soft_q) begin
						state_q <= HPC_RUN;
					end
				end
			endcase
		end
	end

	// Registered outputs
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			host_rdata_out <= 32'h0000_0000;
			cpu_rdata_out <= 32'h0000_0000;
			host_ardata_out <= HPC_ADDR_RST;
			host_irq_n_out <= 1'b1;
			lsh_first_out <= 1'b0;
			port_halt_out <= 1'b0;
			fetch_req_out <= 1'b0;
			wr_addr_out <= HPC_ADDR_RST;
			rd_addr_out <= HPC_ADDR_RST;
		end else begin
			host_irq_n_out <= !c2h_q;
			lsh_first_out <= halfword_order_q;
			port_halt_out <= (state_q == HPC_HALT);
			fetch_req_out <= host_ctl_wr && host_wdata_in[HPC_FETCH_BIT];
			wr_addr_out <= waddr_q;
			rd_addr_out <= raddr_q;
			host_ardata_out <= (atgt == HPC_ATGT_READ) ? raddr_q : waddr_q;
			if (host_rd_in) begin
				unique case (host_addr_in)
					HPC_OFS_EMU_CTRL: host_rdata_out <= {30'h0, soft_q, free_q};
					HPC_OFS_PORT_CTRL: host_rdata_out <= ctl_word;
					HPC_OFS_WR_ADDR: host_rdata_out <= waddr_q;
					HPC_OFS_RD_ADDR: host_rdata_out <= raddr_q;
					default: host_rdata_out <= 32'h0000_0000;
				endcase
			end
			if (cpu_rd_in) begin
				unique case (cpu_addr_in)
					HPC_OFS_EMU_CTRL: cpu_rdata_out <= {30'h0, soft_q, free_q};
					HPC_OFS_PORT_CTRL: cpu_rdata_out <= ctl_word;
					HPC_OFS_WR_ADDR: cpu_rdata_out <= waddr_q;
					HPC_OFS_RD_ADDR: cpu_rdata_out <= raddr_q;
					default: cpu_rdata_out <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule // hpc_regs
`default_nettype wire

// file: tb/hpc_xfer_model.sv
`timescale 1ns/1ps
`default_nettype none
// Transfer engine stand-in: busy for LEN cycles after each start
module hpc_xfer_model #(
	parameter int LEN = 6
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic start_in,
	output logic busy_out
);
	int cnt_q;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			cnt_q <= 0;
		else if (start_in)
			cnt_q <= LEN;
		else if (cnt_q > 0)
			cnt_q <= cnt_q - 1;
	end
	assign busy_out = cnt_q > 0;
endmodule // hpc_xfer_model
`default_nettype wire

// file: tb/hpc_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
module hpc_regs_chk import hpc_pkg::*; (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic host_wr_in,
	input wire logic [7:0] host_addr_in,
	input wire logic [31:0] host_wdata_in,
	input wire logic cpu_wr_in,
	input wire logic [7:0] cpu_addr_in,
	input wire logic [31:0] cpu_wdata_in,
	input wire logic emu_suspend_in,
	input wire logic xfer_busy_in,
	input wire logic port_halt_out,
	input wire logic soft_reset_out,
	input wire logic host_irq_n_out,
	input wire logic cpu_irq_out,
	input wire logic lsh_first_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	logic h_ct, c_ct, h_clr, h_set, c_set, c_srst, stop_q, hold_ok;
	assign h_ct = host_wr_in && host_addr_in == HPC_OFS_PORT_CTRL;
	assign c_ct = cpu_wr_in && cpu_addr_in == HPC_OFS_PORT_CTRL;
	assign h_clr = h_ct && host_wdata_in[HPC_C2H_BIT];
	assign h_set = h_ct && host_wdata_in[HPC_H2C_BIT];
	assign c_set = c_ct && cpu_wdata_in[HPC_C2H_BIT];
	assign c_srst = c_ct && cpu_wdata_in[HPC_SRST_BIT];
	assign hold_ok = emu_suspend_in && !xfer_busy_in && stop_q;
	// Soft-stop mode as last written; host wins a tie
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			stop_q <= 1'b0;
		else if (host_wr_in && host_addr_in == HPC_OFS_EMU_CTRL)
			stop_q <= host_wdata_in[1:0] == 2'h2;
		else if (cpu_wr_in && cpu_addr_in == HPC_OFS_EMU_CTRL)
			stop_q <= cpu_wdata_in[1:0] == 2'h2;
	end
	sequence s_clr;
		h_clr && !c_set;
	endsequence
	sequence s_idle_susp;
		hold_ok [*5];
	endsequence
	property p_set; c_set |-> ##2 !host_irq_n_out; endproperty
	a_set: assert property (p_set) else $error("irq pin not set");
	property p_clr; s_clr |-> ##2 host_irq_n_out; endproperty
	a_clr: assert property (p_clr) else $error("irq pin not cleared");
	property p_rise; $rose(host_irq_n_out) |-> $past(h_clr, 2); endproperty
	a_rise: assert property (p_rise) else $error("irq pin cleared alone");
	property p_cirq; cpu_irq_out |-> $past(h_set) && !$past(cpu_irq_out); endproperty
	a_cirq: assert property (p_cirq) else $error("stray cpu irq");
	property p_srst; c_srst |-> ##[1:2] soft_reset_out; endproperty
	a_srst: assert property (p_srst) else $error("no soft reset");
	property p_halfword_order; h_ct && host_wdata_in[HPC_HALFWORD_ORDER_BIT] |-> ##[1:2] lsh_first_out; endproperty
	a_halfword_order: assert property (p_halfword_order) else $error("order bit lost");
	property p_halt; s_idle_susp |-> port_halt_out; endproperty
	a_halt: assert property (p_halt) else $error("no halt");
	property p_run; !stop_q [*4] |-> !port_halt_out; endproperty
	a_run: assert property (p_run) else $error("halt in run mode");
	property p_busy; xfer_busy_in [*4] |-> !$rose(port_halt_out); endproperty
	a_busy: assert property (p_busy) else $error("halt while busy");
endmodule // hpc_regs_chk
bind hpc_regs hpc_regs_chk u_chk (
	.clk_in(clk_in),
	.rst_n_in(rst_n_in),
	.host_wr_in(host_wr_in),
	.host_addr_in(host_addr_in),
	.host_wdata_in(host_wdata_in),
	.cpu_wr_in(cpu_wr_in),
	.cpu_addr_in(cpu_addr_in),
	.cpu_wdata_in(cpu_wdata_in),
	.emu_suspend_in(emu_suspend_in),
	.xfer_busy_in(xfer_busy_in),
	.port_halt_out(port_halt_out),
	.soft_reset_out(soft_reset_out),
	.host_irq_n_out(host_irq_n_out),
	.cpu_irq_out(cpu_irq_out),
	.lsh_first_out(lsh_first_out)
);
`default_nettype wire

// file: tb/hpc_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module hpc_regs_test import hpc_pkg::*;;
	localparam logic H = 1'h1, C = 1'h0;
	localparam logic [7:0] CT = HPC_OFS_PORT_CTRL, EM = HPC_OFS_EMU_CTRL;
	localparam logic [7:0] WA = HPC_OFS_WR_ADDR, RA = HPC_OFS_RD_ADDR;
	logic clk_in = '0, rst_n_in = '0, host_boot_in = '0, host_wr_in = '0, host_rd_in = '0;
	logic host_aw_in = '0, cpu_wr_in = '0, cpu_rd_in = '0, emu_suspend_in = '0, start_in = '0;
	logic [7:0] host_addr_in = '0, cpu_addr_in = '0;
	logic [31:0] host_wdata_in = '0, host_awdata_in = '0, cpu_wdata_in = '0;
	logic [31:0] host_rdata_out, host_ardata_out, cpu_rdata_out, wr_addr_out, rd_addr_out;
	logic xfer_busy_in, port_halt_out, soft_reset_out, host_irq_n_out, cpu_irq_out;
	logic lsh_first_out, fetch_req_out;
	int n_errors = 0, compares = 0, n_ci = 0, n_sr = 0, n_fr = 0;
	hpc_regs uut (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.host_boot_in(host_boot_in),
		.host_wr_in(host_wr_in),
		.host_rd_in(host_rd_in),
		.host_addr_in(host_addr_in),
		.host_wdata_in(host_wdata_in),
		.host_rdata_out(host_rdata_out),
		.host_aw_in(host_aw_in),
		.host_awdata_in(host_awdata_in),
		.host_ardata_out(host_ardata_out),
		.cpu_wr_in(cpu_wr_in),
		.cpu_rd_in(cpu_rd_in),
		.cpu_addr_in(cpu_addr_in),
		.cpu_wdata_in(cpu_wdata_in),
		.cpu_rdata_out(cpu_rdata_out),
		.emu_suspend_in(emu_suspend_in),
		.xfer_busy_in(xfer_busy_in),
		.port_halt_out(port_halt_out),
		.soft_reset_out(soft_reset_out),
		.host_irq_n_out(host_irq_n_out),
		.cpu_irq_out(cpu_irq_out),
		.lsh_first_out(lsh_first_out),
		.fetch_req_out(fetch_req_out),
		.wr_addr_out(wr_addr_out),
		.rd_addr_out(rd_addr_out)
	);
	hpc_xfer_model xm (.clk_in(clk_in), .rst_n_in(rst_n_in), .start_in(start_in),
		.busy_out(xfer_busy_in));
	always #5 clk_in = ~clk_in;
	always @(negedge clk_in) begin
		n_ci += cpu_irq_out;
		n_sr += soft_reset_out;
		n_fr += fetch_req_out;
	end
	task automatic complete_run;
		if (n_errors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	task automatic wr(input logic h, input logic [7:0] a, input logic [31:0] d);
		@(negedge clk_in);
		{host_wr_in, cpu_wr_in} = {h, !h};
		{host_addr_in, cpu_addr_in} = {a, a};
		{host_wdata_in, cpu_wdata_in} = {d, d};
		@(negedge clk_in);
		{host_wr_in, cpu_wr_in} = 2'h0;
	endtask
	task automatic rd(input logic h, input logic [7:0] a, input logic [31:0] e);
		@(negedge clk_in);
		{host_rd_in, cpu_rd_in} = {h, !h};
		{host_addr_in, cpu_addr_in} = {a, a};
		@(negedge clk_in);
		{host_rd_in, cpu_rd_in} = 2'h0;
		chk(h ? host_rdata_out : cpu_rdata_out, e);
	endtask
	task automatic aw(input logic [31:0] d);
		@(negedge clk_in);
		host_aw_in = 1'h1;
		host_awdata_in = d;
		@(negedge clk_in);
		host_aw_in = 1'h0;
		cyc(2);
	endtask
	task automatic do_reset(input logic boot);
		@(negedge clk_in);
		rst_n_in = 1'h0;
		host_boot_in = boot;
		cyc(6);
		rst_n_in = 1'h1;
		cyc(3);
	endtask
	task automatic t_reset;
		do_reset(H);
		rd(H, CT, 32'h8);
		do_reset(C);
		rd(C, CT, 32'h88);
		chk(host_irq_n_out, 32'h1);
		wr(C, CT, 32'h0);
		rd(C, CT, 32'h8);
		rd(H, EM, 32'h0);
	endtask
	task automatic t_owner;
		wr(H, CT, 32'hA01);
		rd(H, CT, 32'hB09);
		chk(lsh_first_out, 32'h1);
		wr(C, CT, 32'h0);
		rd(C, CT, 32'hB09);
		wr(H, CT, 32'h300);
		rd(H, CT, 32'h208);
		chk(lsh_first_out, 32'h0);
	endtask
	task automatic t_addr;
		aw(32'h1110);
		chk(wr_addr_out, 32'h1110);
		chk(rd_addr_out, 32'h0);
		wr(H, CT, 32'hA00);
		aw(32'h2220);
		chk(rd_addr_out, 32'h2220);
		chk(wr_addr_out, 32'h1110);
		wr(H, CT, 32'h0);
		aw(32'h3330);
		chk(rd_addr_out, 32'h3330);
		chk(host_ardata_out, 32'h3330);
		wr(C, WA, 32'h4440);
		wr(C, RA, 32'h5550);
		rd(C, WA, 32'h4440);
		rd(H, RA, 32'h5550);
		rd(H, 8'h10, 32'h0);
	endtask
	task automatic t_irq;
		wr(C, CT, 32'h4);
		cyc(2);
		chk(host_irq_n_out, 32'h0);
		rd(C, CT, 32'hC);
		wr(H, CT, 32'h0);
		cyc(2);
		chk(host_irq_n_out, 32'h0);
		wr(H, CT, 32'h4);
		cyc(2);
		chk(host_irq_n_out, 32'h1);
		wr(H, CT, 32'h2);
		wr(H, CT, 32'h2);
		cyc(3);
		chk(n_ci, 32'h1);
		rd(C, CT, 32'hA);
		wr(C, CT, 32'h2);
		rd(C, CT, 32'h8);
		wr(C, CT, 32'h80);
		cyc(3);
		chk(n_sr, 32'h1);
		wr(C, CT, 32'h0);
		wr(H, CT, 32'h10);
		cyc(3);
		chk(n_fr, 32'h1);
		rd(H, CT, 32'h8);
	endtask
	task automatic t_emu;
		for (int i = 0; i < 4; i++) begin
			wr(H, EM, 32'(i));
			emu_suspend_in = 1'h1;
			cyc(6);
			chk(port_halt_out, 32'(i == 2));
			emu_suspend_in = 1'h0;
			cyc(4);
			chk(port_halt_out, 32'h0);
		end
		rd(C, EM, 32'h3);
		wr(H, EM, 32'h2);
		start_in = 1'h1;
		cyc(1);
		start_in = 1'h0;
		emu_suspend_in = 1'h1;
		cyc(4);
		chk(port_halt_out, 32'h0);
		cyc(6);
		chk(port_halt_out, 32'h1);
		wr(H, EM, 32'h3);
		cyc(3);
		chk(port_halt_out, 32'h0);
		emu_suspend_in = 1'h0;
	endtask
	initial begin
		#50000;
		n_errors++;
		complete_run;
	end
	initial begin
		t_reset;
		t_owner;
		t_addr;
		t_irq;
		t_emu;
		complete_run;
	end
endmodule // hpc_regs_test
`default_nettype wire
